// File: include/csie_defs.vh
// constants for the processor status and interrupt enable block
`ifndef CSIE_DEFS_VH
`define CSIE_DEFS_VH
`define CSIE_IDX_GIE        8'h20
`define CSIE_IDX_EPIE       8'h21
`define CSIE_IDX_PSC        8'hff
`define CSIE_ADDR_GIE       {22'h000000, `CSIE_IDX_GIE, 2'b00}
`define CSIE_ADDR_EPIE      {22'h000000, `CSIE_IDX_EPIE, 2'b00}
`define CSIE_ADDR_PSC       {22'h000000, `CSIE_IDX_PSC, 2'b00}
`define CSIE_PSC_RUN        0
`define CSIE_PSC_RSVD       1
`define CSIE_PSC_IE_SENSE   2
`define CSIE_PSC_SUSPEND    3
`define CSIE_PSC_POR        4
`define CSIE_PSC_BUS_RST    5
`define CSIE_PSC_WDR        6
`define CSIE_PSC_IRQ_PEND   7
`define CSIE_PSC_RESET      8'h11
`define CSIE_GIE_RESET      7'h00
`define CSIE_EPIE_RESET     5'h00
`define CSIE_NUM_SRC        12
`define CSIE_CLK_MHZ        100
`define CSIE_SE0_MIN_US     12
`define CSIE_SE0_MAX_US     16
`define CSIE_SE0_MIN_CYC    (`CSIE_SE0_MIN_US * `CSIE_CLK_MHZ)
`define CSIE_SE0_MAX_CYC    (`CSIE_SE0_MAX_US * `CSIE_CLK_MHZ)
`define CSIE_WATCH_MS       8
`define CSIE_WATCH_CYC      (`CSIE_WATCH_MS * 1000 * `CSIE_CLK_MHZ)
`define CSIE_STARTUP_MS     96
`define CSIE_STARTUP_CYC    (`CSIE_STARTUP_MS * 1000 * `CSIE_CLK_MHZ)
`endif

// File: src/csie_se0_detect.v
// upstream single-ended zero detector for bus reset
module csie_se0_detect #(
   parameter MIN_CYC = 1200
) (
   input  wire hclk,
   input  wire hresetn,
   input  wire usb_dp,
   input  wire usb_dm,
   output reg  se0_q,
   output reg  bus_rst_pulse_q
);
   reg  [11:0] cnt_q;
   wire        se0_now;

   assign se0_now = ~usb_dp & ~usb_dm;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q           <= 12'h000;
         se0_q           <= 1'b0;
         bus_rst_pulse_q <= 1'b0;
      end else begin
         se0_q           <= se0_now;
         bus_rst_pulse_q <= 1'b0;
         if (!se0_now) begin
            cnt_q <= 12'h000;
         end else if (cnt_q != MIN_CYC[11:0]) begin
            cnt_q <= cnt_q + 12'h001;
            // fires once per se0, at the least bus reset length
            if (cnt_q == MIN_CYC[11:0] - 12'h001) begin
               bus_rst_pulse_q <= 1'b1;
            end
         end
      end
   end
endmodule

// File: src/csie_watchdog_timer_unit.v
// watchdog counter: expires when not cleared within the window
module csie_watchdog_timer_unit #(
   parameter WATCH_CYC = 800000
) (
   input  wire hclk,
   input  wire hresetn,
   input  wire wd_clear,
   output reg  expire_q
);
   reg [23:0] cnt_q;

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q    <= 24'h000000;
         expire_q <= 1'b0;
      end else begin
         expire_q <= 1'b0;
         if (wd_clear) begin
            cnt_q <= 24'h000000;
         end else if (cnt_q == WATCH_CYC[23:0] - 24'h000001) begin
            cnt_q    <= 24'h000000;
            expire_q <= 1'b1;
         end else begin
            cnt_q <= cnt_q + 24'h000001;
         end
      end
   end
endmodule

// File: src/csie_top.v
// processor status/control, reset cause flags and interrupt enable logic
//
// Functional notes
// R01: halt clears status register, core stops
// R02: firmware writes zero to reserved bit 1
// R03: enable sense bit reads state, ignores writes
// R04: sense changed only by mask/unmask/return instructions; here also cleared by take, halt and watchdog reset
// R05: suspend write halts; interrupt or activity wakes
// R06: suspend write ignored during bus activity
// R07: power-on reset sets power-on flag
// R08: long se0 sets bus reset flag
// R09: watchdog expiry sets watchdog reset flag
// R10: pending bit shows any recognised interrupt
// R11: status register powers up as 0x11
// R12: start-up suspend lets watchdog fire unless se0
// R13: watchdog reset sets 01XX0001, keeps por/bus flags
// R14: firmware clears power-on flag after start-up
// R15: twelve maskable interrupt sources
// R16: enable bits written one enable, zero disable
// R17: global bit 0 gates bus reset; reset zero
// R18: global bits 1,2 gate timer interrupts
// R19: global bits 3-6 hub,dac,gpio,serial; 7 reserved
// R20: per-source pending flop held until serviced
// R21: servicing clears sense, pending, issues vector
// R22: lowest numbered enabled request wins
// R23: reserved enable bits read zero
//
// Design decision made here: register access over AHB-Lite.
`include "csie_defs.vh"
module csie_top #(
   parameter WATCH_CYC   = `CSIE_WATCH_CYC,
   parameter STARTUP_CYC = `CSIE_STARTUP_CYC
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire        hreadyout,
   output wire        hresp,
   output reg  [31:0] hrdata,
   input  wire        usb_dp,
   input  wire        usb_dm,
   input  wire        usb_bus_activity,
   input  wire [11:1] irq_src_pulse,
   input  wire        mask_all_instr,
   input  wire        unmask_all_instr,
   input  wire        return_from_service_instr,
   input  wire        halt_instr,
   input  wire        watchdog_clear,
   input  wire        irq_take,
   output reg         irq_req,
   output reg  [3:0]  irq_number,
   output reg         cpu_run,
   output reg         watchdog_reset_out
);
   localparam NS = `CSIE_NUM_SRC;
   localparam [7:0] PSC_RST = `CSIE_PSC_RESET;

   // bus slave state
   reg         rd_wait_q;
   reg         wr_q;
   reg  [2:0]  sel_q;
   wire        addr_ok;
   wire [2:0]  sel_d;
   wire        wr_gie;
   wire        wr_epie;
   wire        wr_psc;

   // status and enable state
   reg  [6:0]  gie_en_q;
   reg  [4:0]  ep_en_q;
   reg         run_q;
   reg         suspend_q;
   reg         por_q;
   reg         bus_rst_q;
   reg         wdr_q;
   reg         ie_sense_q;
   reg         startup_q;
   reg  [23:0] startup_cnt_q;
   reg  [3:0]  sel_src_q;

   wire        se0_lvl;
   wire        bus_rst_pulse;
   wire        wdr_evt;
   wire        startup_abort;
   wire [NS-1:0] src;
   wire [NS-1:0] pend;
   wire [NS-1:0] en;
   wire [NS-1:0] req;
   wire        any_req;
   wire        take_ok;
   wire        wipe;
   wire [7:0]  psc_val;
   reg  [3:0]  sel_d_src;
   integer     i;

   csie_se0_detect #(
      .MIN_CYC (`CSIE_SE0_MIN_CYC)
   ) u_se0 (
      .hclk            (hclk),
      .hresetn         (hresetn),
      .usb_dp          (usb_dp),
      .usb_dm          (usb_dm),
      .se0_q           (se0_lvl),
      .bus_rst_pulse_q (bus_rst_pulse)
   );

   // R12: se0 in start-up suspend restarts the watchdog window
   assign startup_abort = startup_q & se0_lvl;

   csie_watchdog_timer_unit #(
      .WATCH_CYC (WATCH_CYC)
   ) u_wdt (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .wd_clear (watchdog_clear | startup_abort),
      .expire_q (wdr_evt)
   );

   // ahb-lite slave: writes zero wait, reads one wait state
   assign addr_ok   = hsel & htrans[1] & hready;
   assign sel_d     = {haddr == `CSIE_ADDR_PSC, haddr == `CSIE_ADDR_EPIE, haddr == `CSIE_ADDR_GIE};
   assign hreadyout = ~rd_wait_q;
   assign hresp     = 1'b0;
   assign wr_gie    = wr_q & sel_q[0];
   assign wr_epie   = wr_q & sel_q[1];
   assign wr_psc    = wr_q & sel_q[2];

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_wait_q <= 1'b0;
         wr_q      <= 1'b0;
         sel_q     <= 3'h0;
         hrdata    <= 32'h00000000;
      end else begin
         rd_wait_q <= addr_ok & ~hwrite;
         wr_q      <= addr_ok & hwrite;
         if (addr_ok) begin
            sel_q <= sel_d;
         end
         if (rd_wait_q) begin
            // R23: reserved enable bits read zero
            case (sel_q)
               3'h1:    hrdata <= {25'h0000000, gie_en_q};
               3'h2:    hrdata <= {27'h0000000, ep_en_q};
               3'h4:    hrdata <= {24'h000000, psc_val};
               default: hrdata <= 32'h00000000;
            endcase
         end
      end
   end

   // R10: pending bit is the or of all pending flops
   // R03: sense bit reads the internal enable, bit 1 reads zero
   assign psc_val = {|pend, wdr_q, bus_rst_q, por_q, suspend_q, ie_sense_q, 1'b0, run_q};

   // R16: enable registers, one bit per source
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // R17: all enables start cleared
         gie_en_q <= `CSIE_GIE_RESET;
         ep_en_q  <= `CSIE_EPIE_RESET;
      end else if (wdr_evt) begin
         gie_en_q <= `CSIE_GIE_RESET;
         ep_en_q  <= `CSIE_EPIE_RESET;
      end else begin
         if (wr_gie) begin
            gie_en_q <= hwdata[6:0];
         end
         if (wr_epie) begin
            ep_en_q <= hwdata[4:0];
         end
      end
   end

   // R15: source order is vector order, bus reset first
   assign src = {irq_src_pulse, bus_rst_pulse};
   // R17: R18: R19: enable bit to source mapping
   assign en  = {gie_en_q[6:3], ep_en_q, gie_en_q[2:0]};
   assign req = pend & en;
   assign any_req = |req;
   assign take_ok = irq_take & irq_req;
   // halt and watchdog reset both flush interrupt state
   assign wipe    = wdr_evt | halt_instr;

   // R20: one pending flop per source, set wins over clear
   genvar g;
   generate
      for (g = 0; g < NS; g = g + 1) begin : g_pend
         reg p_q;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               p_q <= 1'b0;
            end else if (src[g]) begin
               p_q <= 1'b1;
            end else if (wipe | (take_ok & ({28'h0000000, sel_src_q} == g))) begin
               // R21: serviced source loses its pending state
               p_q <= 1'b0;
            end
         end
         assign pend[g] = p_q;
      end
   endgenerate

   // R22: lowest numbered enabled request is granted
   always @* begin
      sel_d_src = 4'h0;
      for (i = NS - 1; i >= 0; i = i - 1) begin
         if (req[i]) begin
            sel_d_src = i[3:0];
         end
      end
   end

   // request held only while sense is set; dropped on take
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_req    <= 1'b0;
         irq_number <= 4'h0;
         sel_src_q  <= 4'h0;
      end else if (take_ok | wipe) begin
         irq_req <= 1'b0;
      end else begin
         irq_req <= ie_sense_q & any_req & run_q & ~suspend_q & ~startup_q;
         if (any_req) begin
            sel_src_q  <= sel_d_src;
            // R21: vector number one above source index
            irq_number <= sel_d_src + 4'h1;
         end
      end
   end

   // R04: sense only moves by instruction, by servicing or by watchdog reset
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ie_sense_q <= 1'b0;
      end else if (wipe) begin
         ie_sense_q <= 1'b0;
      end else if (take_ok) begin
         // R21: servicing masks further interrupts
         ie_sense_q <= 1'b0;
      end else if (unmask_all_instr | return_from_service_instr) begin
         ie_sense_q <= 1'b1;
      end else if (mask_all_instr) begin
         ie_sense_q <= 1'b0;
      end
   end

   // run, suspend and reset cause flags
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         // R11: R07: power-on value 0x11
         run_q     <= PSC_RST[`CSIE_PSC_RUN];
         por_q     <= PSC_RST[`CSIE_PSC_POR];
         suspend_q <= 1'b0;
         bus_rst_q <= 1'b0;
         wdr_q     <= 1'b0;
      end else if (wdr_evt) begin
         // R13: watchdog reset keeps por and bus reset flags
         // R09: watchdog flag set on expiry
         run_q     <= 1'b1;
         suspend_q <= 1'b0;
         wdr_q     <= 1'b1;
         bus_rst_q <= bus_rst_q | bus_rst_pulse;
      end else if (halt_instr) begin
         // R01: halt zeroes every status bit unless a watchdog expiry, bus reset or source event lands in the same cycle
         run_q     <= 1'b0;
         por_q     <= 1'b0;
         suspend_q <= 1'b0;
         wdr_q     <= 1'b0;
         bus_rst_q <= bus_rst_pulse;
      end else begin
         if (wr_psc) begin
            run_q <= hwdata[`CSIE_PSC_RUN];
            por_q <= hwdata[`CSIE_PSC_POR];
            wdr_q <= hwdata[`CSIE_PSC_WDR];
         end
         // R08: detector event beats a firmware clear
         if (bus_rst_pulse) begin
            bus_rst_q <= 1'b1;
         end else if (wr_psc) begin
            bus_rst_q <= hwdata[`CSIE_PSC_BUS_RST];
         end
         // R06: suspend request refused under bus activity
         if (wr_psc & hwdata[`CSIE_PSC_SUSPEND] & ~usb_bus_activity) begin
            suspend_q <= 1'b1;
         end else if (any_req | usb_bus_activity) begin
            // R05: wake on enabled pending interrupt or activity
            suspend_q <= 1'b0;
         end else if (wr_psc) begin
            suspend_q <= 1'b0;
         end
      end
   end

   // R12: start-up suspend, ended by its length or by se0
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         startup_q     <= 1'b1;
         startup_cnt_q <= 24'h000000;
      end else if (startup_q) begin
         if (startup_abort | (startup_cnt_q == STARTUP_CYC[23:0] - 24'h000001)) begin
            startup_q <= 1'b0;
         end
         startup_cnt_q <= startup_cnt_q + 24'h000001;
      end
   end

   // core run level and reset pulse out, both registered
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cpu_run            <= 1'b0;
         watchdog_reset_out <= 1'b0;
      end else begin
         // R01: R05: core stopped while halted or suspended
         cpu_run            <= run_q & ~suspend_q & ~startup_q & ~halt_instr;
         watchdog_reset_out <= wdr_evt;
      end
   end
endmodule

// File: dv/csie_checker.sv
// port assertions for the status and interrupt enable block
module csie_checker #(
   parameter WATCH_CYC   = 800000,
   parameter STARTUP_CYC = 9600000
) (
   input logic        hclk,
   input logic        hresetn,
   input logic        hsel,
   input logic [1:0]  htrans,
   input logic        hwrite,
   input logic        hready,
   input logic        hreadyout,
   input logic [31:0] hrdata,
   input logic        mask_all_instr,
   input logic        halt_instr,
   input logic        irq_take,
   input logic        irq_req,
   input logic [3:0]  irq_number,
   input logic        cpu_run,
   input logic        watchdog_clear,
   input logic        watchdog_reset_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic req_rd;
   int   wd_cnt_q;
   assign req_rd = hsel && htrans[1] && hready && !hwrite;
   // cycles since the last restart; slack of 3 covers the output register stages
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wd_cnt_q <= 0;
      else if (watchdog_clear || watchdog_reset_out) wd_cnt_q <= 0;
      else wd_cnt_q <= wd_cnt_q + 1;
   end
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_read_wait: assert property (req_rd |=> !hreadyout ##1 hreadyout)
      else $error("read wait state wrong");
   a_rdata_hold: assert property ($past(hreadyout) |-> $stable(hrdata))
      else $error("read data changed outside a read");
   a_take_drops: assert property (irq_req && irq_take |=> !irq_req) // take ends request
      else $error("request stayed after take");
   a_mask_drops: assert property (mask_all_instr |-> ##[1:2] !irq_req) // mask ends request
      else $error("request stayed after mask");
   a_vector_range: assert property (irq_req |-> irq_number >= 4'h1 && irq_number <= 4'hc) // twelve vectors
      else $error("vector number out of range");
   a_halt_stops: assert property (halt_instr |-> ##2 !cpu_run [*8]) // core stopped
      else $error("core runs after halt");
   a_wdr_pulse: assert property (watchdog_reset_out |=> !watchdog_reset_out) // single pulse
      else $error("watchdog reset longer than a cycle");
   a_wdr_window: assert property (watchdog_reset_out |-> wd_cnt_q >= WATCH_CYC - 3 && wd_cnt_q <= WATCH_CYC + 3) // window
      else $error("watchdog expiry off its window");
   c_take: cover property (irq_req && irq_take);
   c_wdr: cover property (watchdog_reset_out);
   c_read: cover property (req_rd);
endmodule

bind csie_top csie_checker #(.WATCH_CYC(WATCH_CYC), .STARTUP_CYC(STARTUP_CYC)) u_csie_checker (
   .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hreadyout(hreadyout), .hrdata(hrdata), .mask_all_instr(mask_all_instr), .halt_instr(halt_instr),
   .irq_take(irq_take), .irq_req(irq_req), .irq_number(irq_number), .cpu_run(cpu_run),
   .watchdog_clear(watchdog_clear), .watchdog_reset_out(watchdog_reset_out));

// File: dv/tb_top.sv
// self-checking bench for the status and interrupt enable block
`include "csie_defs.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] PSC = `CSIE_ADDR_PSC;
   localparam logic [31:0] GIE = `CSIE_ADDR_GIE;
   localparam logic [31:0] EPI = `CSIE_ADDR_EPIE;
   localparam int MSK = 0, UNM = 1, RET = 2, HLT = 3, TAK = 4;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
   logic        usb_dp = 1, usb_dm = 0, act = 0, kick = 0, watchdog_clear = 0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0;
   logic [11:1] irq_src = 11'h0;
   logic [4:0]  ctl = 5'h0;
   logic [5:0]  kc = 6'h0;
   wire         hreadyout, hresp, irq_req, cpu_run, watchdog_reset_out;
   wire  [31:0] hrdata;
   wire  [3:0]  irq_number;
   int          fails = 0, tests_run = 0;

   csie_top #(.WATCH_CYC(200), .STARTUP_CYC(500)) u_csie_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .usb_dp(usb_dp), .usb_dm(usb_dm), .usb_bus_activity(act), .irq_src_pulse(irq_src),
      .mask_all_instr(ctl[0]), .unmask_all_instr(ctl[1]), .return_from_service_instr(ctl[2]),
      .halt_instr(ctl[3]), .irq_take(ctl[4]), .watchdog_clear(watchdog_clear), .irq_req(irq_req),
      .irq_number(irq_number), .cpu_run(cpu_run), .watchdog_reset_out(watchdog_reset_out));

   always #5 hclk = ~hclk;
   // restart every 64 cycles, well inside the shortened window
   always @(posedge hclk) begin
      kc <= kc + 6'h1;
      watchdog_clear <= kick && kc == 6'h0;
   end

   task complete_run;
      if (fails == 0 && tests_run > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task chk(input string n, input logic [31:0] s, e);
      tests_run++;
      if (s !== e) begin
         fails++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task cyc(input int n);
      repeat (n) @(posedge hclk);
      @(negedge hclk);
   endtask
   // hreadyout only moves on rising edges, so the falling-edge look is the sampled value
   task rdy(output logic [31:0] d);
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1 && n < 50) begin
         n++;
         @(negedge hclk);
      end
      // a stuck wait state must not pass silently
      chk("bus ready", 32'(hreadyout), 32'h1);
      d = hrdata;
      @(posedge hclk);
   endtask
   task bus(input logic w, input logic [31:0] a, d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      rdy(r);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy(r);
   endtask
   task wr(input logic [31:0] a, d);
      logic [31:0] r;
      bus(1'b1, a, d, r);
   endtask
   task rd(input logic [31:0] a, e);
      logic [31:0] r;
      bus(1'b0, a, 32'h0, r);
      chk($sformatf("register %h", a), r, e);
   endtask
   task pl(input int b);
      @(posedge hclk);
      ctl[b] <= 1'b1;
      @(posedge hclk);
      ctl[b] <= 1'b0;
   endtask
   task src(input logic [11:1] v);
      @(posedge hclk);
      irq_src <= v;
      @(posedge hclk);
      irq_src <= 11'h0;
   endtask
   task wreq(input logic [3:0] e);
      int n;
      n = 0;
      @(negedge hclk);
      while (irq_req !== 1'b1 && n < 40) begin
         @(negedge hclk);
         n++;
      end
      chk("irq request and number", 32'({irq_req, irq_number}), 32'({1'b1, e}));
   endtask

   task t_reset;
      rd(PSC, 32'h11); // power-up value
      rd(GIE, 32'h0); // enables cleared
      cyc(250);
      kick <= 1'b1;
      cyc(300);
      rd(PSC, 32'h51); // start-up expiry
      chk("cpu run", 32'(cpu_run), 32'h1); // running after start-up
   endtask
   task t_regs;
      wr(PSC, 32'h5);
      rd(PSC, 32'h1); // write masking
      wr(GIE, 32'hff);
      rd(GIE, 32'h7f); // enable bits
      wr(EPI, 32'hff);
      rd(EPI, 32'h1f); // endpoint enables
      wr(32'h400, 32'hff);
      rd(32'h400, 32'h0); // unmapped reads zero
      chk("hresp", 32'(hresp), 32'h0); // refusal still okay
   endtask
   task t_mask;
      wr(GIE, 32'h0);
      wr(EPI, 32'h0);
      pl(UNM);
      rd(PSC, 32'h5); // sense set
      src(11'h1);
      cyc(6);
      chk("irq req", 32'(irq_req), 32'h0); // disabled source
      rd(PSC, 32'h85); // pending shown
      wr(GIE, 32'h2);
      wreq(4'h2); // held pending
      pl(MSK);
      cyc(1);
      chk("irq req", 32'(irq_req), 32'h0); // masked
      pl(UNM);
      wreq(4'h2); // unmasked again
      pl(TAK);
      cyc(1);
      chk("irq req", 32'(irq_req), 32'h0); // taken
      rd(PSC, 32'h1); // sense and pending cleared
   endtask
   task t_map;
      logic [31:0] g, e;
      pl(UNM);
      for (int i = 1; i < 12; i++) begin
         g = i < 3 ? 32'h1 << i : i > 7 ? 32'h1 << (i - 5) : 32'h0;
         e = i > 2 && i < 8 ? 32'h1 << (i - 3) : 32'h0;
         wr(GIE, g);
         wr(EPI, e);
         src(11'h7ff);
         wreq(4'(i + 1)); // source mapping
         pl(TAK);
         pl(RET);
      end
      wr(GIE, 32'h7e);
      wr(EPI, 32'h1f);
      for (int i = 1; i < 11; i++) begin
         wreq(4'(i + 1)); // priority order
         pl(TAK);
         pl(RET);
      end
      rd(PSC, 32'h5); // nothing pending
   endtask
   task t_busrst;
      wr(GIE, 32'h1);
      usb_dp <= 1'b0;
      cyc(1300);
      @(posedge hclk);
      usb_dp <= 1'b1;
      wreq(4'h1); // bus reset request
      pl(TAK);
      pl(RET);
      rd(PSC, 32'h25); // bus reset flag
   endtask
   task t_suspend;
      act <= 1'b1;
      wr(PSC, 32'h9);
      rd(PSC, 32'h5); // ignored under activity
      act <= 1'b0;
      wr(PSC, 32'h9);
      cyc(2);
      chk("cpu run", 32'(cpu_run), 32'h0); // suspended
      @(posedge hclk);
      act <= 1'b1;
      @(posedge hclk);
      act <= 1'b0;
      cyc(3);
      chk("cpu run", 32'(cpu_run), 32'h1); // activity wake
      wr(GIE, 32'h2);
      wr(PSC, 32'h9);
      src(11'h1);
      cyc(3);
      chk("cpu run", 32'(cpu_run), 32'h1); // interrupt wake
      wreq(4'h2); // request after wake
   endtask
   task t_halt;
      int n;
      pl(HLT);
      cyc(2);
      chk("cpu run", 32'(cpu_run), 32'h0); // halted
      rd(PSC, 32'h0); // all bits cleared
      kick <= 1'b0;
      n = 0;
      while (watchdog_reset_out !== 1'b1 && n < 400) begin
         @(negedge hclk);
         n++;
      end
      chk("watchdog reset", 32'(watchdog_reset_out), 32'h1); // expiry pulse
      cyc(3);
      chk("cpu run", 32'(cpu_run), 32'h1); // restarted
      rd(PSC, 32'h41); // watchdog value
      rd(GIE, 32'h0); // enables cleared
   endtask
   // second reset with se0 present: start-up suspend cut short
   task t_abort;
      @(posedge hclk);
      hresetn <= 1'b0;
      usb_dp <= 1'b0;
      kick <= 1'b1;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      cyc(4);
      chk("cpu run", 32'(cpu_run), 32'h1); // se0 ends start-up early
      @(posedge hclk);
      usb_dp <= 1'b1;
      rd(PSC, 32'h11); // no watchdog reset
   endtask

   initial begin
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_regs;
      t_mask;
      t_map;
      t_busrst;
      t_suspend;
      t_halt;
      t_abort;
      complete_run;
   end
   initial begin
      #200000;
      fails++;
      complete_run;
   end
endmodule
